// File: sim/adc_gain_correction_bench.sv
module adc_gain_correction_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import agc_pkg::*;
  logic         sys_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic         hreadyout, hresp, so_a, so_b;
  logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic [1:0]   htrans = 2'h0;
  logic [27:0]  codes = 28'h0;
  agc_pair_type raw_in, corr_out;
  int           failures = 0, checks = 0, cyc = 0;
  logic [6:0]   gains [7] = '{7'h01, 7'h20, 7'h3F, 7'h40, 7'h41, 7'h7F, 7'h00};

  agc_top DUT (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .raw_in, .corr_out,
    .serial_result_out_first(so_a), .serial_result_out_second(so_b));
  agc_conv_model u_conv (.sys_clk, .resetn, .go, .codes, .raw_in);

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      failures++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rv = hrdata;
  endtask

  function automatic logic [13:0] ex(input logic [13:0] c, input logic [6:0] g);
    int s, p;
    s = int'($signed(c));
    p = (s * int'(g[5:0]) + 2048) >>> 12;
    p = g[6] ? s + p : s - p;
    p = p > 8191 ? 8191 : p < -8192 ? -8192 : p;
    return p[13:0];
  endfunction

  task automatic smp(input logic [27:0] c, input logic [6:0] ga, input logic [6:0] gb);
    logic [13:0] sa, sb;
    go <= 1'b1;
    codes <= c;
    @(posedge sys_clk);
    go <= 1'b0;
    for (int i = 0; i < 9 && corr_out.valid !== 1'b1; i++) @(posedge sys_clk);
    chk(32'(corr_out.code_a), 32'(ex(c[27:14], ga)));
    chk(32'(corr_out.code_b), 32'(ex(c[13:0], gb)));
    for (int i = 13; i >= 0; i--)
    begin
      sa[i] = so_a;
      sb[i] = so_b;
      @(posedge sys_clk);
    end
    chk(32'(sa), 32'(ex(c[27:14], ga)));
    chk(32'(sb), 32'(ex(c[13:0], gb)));
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rv, {2'h0, ex(c[13:0], gb), 2'h0, ex(c[27:14], ga)});
    xfer(1'b0, OFS_RAW_IN, 32'h0);
    chk(rv, {2'h0, c[13:0], 2'h0, c[27:14]});
  endtask

  task automatic conclude();
    $display("TB: checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    xfer(1'b0, OFS_GAIN_A, 32'h0);
    chk(rv, 32'(GAIN_RESET));
    smp({14'h1FFF, 14'h2000}, 7'h00, 7'h00);
    $display("TB: reset test done");
    foreach (gains[i])
    begin
      xfer(1'b1, OFS_GAIN_A, 32'hFFFF_FF80 | 32'(gains[i]));
      xfer(1'b1, OFS_GAIN_B, 32'(gains[i] ^ 7'h40));
      xfer(1'b0, OFS_GAIN_A, 32'h0);
      chk(rv, 32'(gains[i]));
      xfer(1'b0, OFS_GAIN_B, 32'h0);
      chk(rv, 32'(gains[i] ^ 7'h40));
      smp({14'h1FFF, 14'h2000}, gains[i], gains[i] ^ 7'h40);
      smp({14'h0800, 14'h3A5B}, gains[i], gains[i] ^ 7'h40);
    end
    xfer(1'b0, 32'h0000_0010, 32'h0);
    chk(rv, 32'h0);
    $display("TB: gain test done");
    conclude();
  end
endmodule

// File: sim/agc_conv_model.sv
module agc_conv_model
  import agc_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              resetn,
  input wire logic              go,
  input wire logic [27:0]       codes,
  output agc_pkg::agc_pair_type raw_in
);
  // Codes invert between samples so stale data never looks valid
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      raw_in <= '0;
    else
      raw_in <= {go, go ? codes : ~raw_in[27:0]};
endmodule

// File: sim/agc_props.sv
module agc_props
  import agc_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire agc_pkg::agc_pair_type raw_in,
  input wire agc_pkg::agc_pair_type corr_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic rg = hsel && htrans[1] && !hwrite && haddr < 32'h8;
  wire logic ru = hsel && htrans[1] && !hwrite && haddr > 32'hC;
  a_bus_ready: assert property (hreadyout) else $error("wait");
  a_resp_okay: assert property (!hresp) else $error("resp");
  a_out_latency: assert property (raw_in.valid |-> ##3 corr_out.valid) else $error("late");
  a_out_cause: assert property (corr_out.valid |-> $past(raw_in.valid, 3)) else $error("cause");
  a_hold_a: assert property (!corr_out.valid |-> $stable(corr_out.code_a)) else $error("a");
  a_hold_b: assert property (!corr_out.valid |-> $stable(corr_out.code_b)) else $error("b");
  a_gain_width: assert property (rg |=> hrdata[31:7] == 25'h0) else $error("width");
  a_unmapped_zero: assert property (ru |=> hrdata == 32'h0) else $error("unmapped");
  c_sample: cover property (corr_out.valid);
  c_gain_read: cover property (rg);
  c_unmapped: cover property (ru);
endmodule

bind agc_top agc_props u_props (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hrdata,
  .hreadyout, .hresp, .raw_in, .corr_out);

// File: verilog/agc_pkg.sv
package agc_pkg;

  localparam int unsigned RESULT_W    = 14;
  localparam int unsigned GAIN_W      = 7;
  localparam int unsigned MAG_W       = 6;
  localparam int unsigned SIGN_POS    = 6;
  localparam int unsigned FRAC_SHIFT  = 12;

  localparam logic [31:0] OFS_GAIN_A  = 32'h0000_0000;
  localparam logic [31:0] OFS_GAIN_B  = 32'h0000_0004;
  localparam logic [31:0] OFS_RAW_IN  = 32'h0000_0008;
  localparam logic [31:0] OFS_STATUS  = 32'h0000_000C;

  localparam logic [6:0]  GAIN_RESET  = 7'h00;
  localparam logic [13:0] CODE_MAX    = 14'h1FFF;
  localparam logic [13:0] CODE_MIN    = 14'h2000;

  typedef struct packed {
    logic        valid;
    logic [13:0] code_a;
    logic [13:0] code_b;
  } agc_pair_type;

  typedef struct packed {
    logic        sign;
    logic [5:0]  mag;
  } agc_gain_type;

endpackage

// File: verilog/agc_scale.sv
module agc_scale
  import agc_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  // Sample in
  input  wire logic                 in_valid,
  input  wire logic [13:0]          in_code,
  input  wire agc_pkg::agc_gain_type gain,
  // Sample out
  output logic                      out_valid,
  output logic [13:0]               out_code
);

  logic signed [21:0] prod;
  logic signed [21:0] corr;
  logic signed [21:0] sum;
  logic [13:0]        res_d;
  logic [13:0]        res_q;
  logic               vld_q;

  always_comb
  begin
    prod = $signed({{8{in_code[13]}}, in_code}) * $signed({16'h0000, gain.mag});
    corr = (prod + 22'sh000800) >>> FRAC_SHIFT;
    if (gain.sign)
      sum = $signed({{8{in_code[13]}}, in_code}) + corr;
    else
      sum = $signed({{8{in_code[13]}}, in_code}) - corr;
    if (sum > $signed({{8{1'b0}}, CODE_MAX}))
      res_d = CODE_MAX;
    else if (sum < $signed({{8{1'b1}}, CODE_MIN}))
      res_d = CODE_MIN;
    else
      res_d = sum[13:0];
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      res_q <= 14'h0000;
      vld_q <= 1'b0;
    end
    else
    begin
      res_q <= res_d;
      vld_q <= in_valid;
    end
  end

  assign out_code  = res_q;
  assign out_valid = vld_q;

endmodule

// File: verilog/agc_top.sv
// The placing of the registers and the AHB-Lite register port were left to the implementer.
module agc_top
  import agc_pkg::*;
(
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic [31:0]        hrdata,
  output logic               hreadyout,
  output logic               hresp,
  // Converter results in
  input  wire agc_pkg::agc_pair_type raw_in,
  // Corrected results out
  output agc_pkg::agc_pair_type      corr_out,
  output logic               serial_result_out_first,
  output logic               serial_result_out_second
);

  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} agc_bus_type;
  typedef enum logic [2:0] {REG_GAIN_A, REG_GAIN_B, REG_RAW, REG_STATUS, REG_NONE} agc_reg_type;

  // Bus tracking
  agc_bus_type  bus_q;
  agc_bus_type  bus_d;
  logic [31:0]  addr_q;
  logic [31:0]  addr_d;
  logic [31:0]  rdata_q;
  logic [31:0]  rdata_d;
  logic         ready_q;
  logic         ready_d;
  logic         resp_q;
  logic         resp_d;

  // Gain registers, index 0 is channel A
  agc_gain_type gain_q [2];
  agc_gain_type gain_d [2];

  // Sample path
  agc_pair_type raw_q;
  agc_pair_type raw_d;
  agc_pair_type out_q;
  agc_pair_type out_d;
  logic [13:0]  raw_code [2];
  logic [1:0]   sc_valid;
  logic [13:0]  sc_code [2];

  // Serial shifters and bits left in each frame
  logic [13:0]  sh_q [2];
  logic [13:0]  sh_d [2];
  logic [3:0]   left_q [2];
  logic [3:0]   left_d [2];

  // Full-word address decode, shared by reads and writes
  function automatic agc_reg_type decode(input logic [31:0] a);
    if (a == OFS_GAIN_A)
      decode = REG_GAIN_A;
    else if (a == OFS_GAIN_B)
      decode = REG_GAIN_B;
    else if (a == OFS_RAW_IN)
      decode = REG_RAW;
    else if (a == OFS_STATUS)
      decode = REG_STATUS;
    else
      decode = REG_NONE;
  endfunction

  function automatic logic [31:0] pack_pair(input agc_pair_type p);
    pack_pair = {2'h0, p.code_b, 2'h0, p.code_a};
  endfunction

  // Address phase capture
  always_comb
  begin
    bus_d  = BUS_IDLE;
    addr_d = addr_q;
    if (hsel && hready && htrans[1])
    begin
      addr_d = haddr;
      bus_d  = hwrite ? BUS_WRITE : BUS_READ;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_q  <= BUS_IDLE;
      addr_q <= 32'h0000_0000;
    end
    else
    begin
      bus_q  <= bus_d;
      addr_q <= addr_d;
    end
  end

  // Read data, launched for the data phase
  // Gains come from the next value, so a write just before is seen
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      case (decode(haddr))
        REG_GAIN_A: rdata_d = {{25{1'b0}}, gain_d[0]};
        REG_GAIN_B: rdata_d = {{25{1'b0}}, gain_d[1]};
        REG_RAW:    rdata_d = pack_pair(raw_q);
        REG_STATUS: rdata_d = pack_pair(out_q);
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // Bus response, zero wait and always OKAY
  always_comb
  begin
    ready_d = 1'b1;
    resp_d  = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end
    else
    begin
      ready_q <= ready_d;
      resp_q  <= resp_d;
    end
  end

  // Gain register writes in the data phase
  always_comb
  begin
    gain_d[0] = gain_q[0];
    gain_d[1] = gain_q[1];
    case (bus_q)
      BUS_WRITE:
      begin
        if (decode(addr_q) == REG_GAIN_A)
          gain_d[0] = hwdata[GAIN_W-1:0];
        if (decode(addr_q) == REG_GAIN_B)
          gain_d[1] = hwdata[GAIN_W-1:0];
      end
      BUS_READ:
      begin
        gain_d[0] = gain_q[0];
        gain_d[1] = gain_q[1];
      end
      default:
      begin
        gain_d[0] = gain_q[0];
        gain_d[1] = gain_q[1];
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gain_q[0] <= GAIN_RESET;
      gain_q[1] <= GAIN_RESET;
    end
    else
    begin
      gain_q[0] <= gain_d[0];
      gain_q[1] <= gain_d[1];
    end
  end

  // Raw capture, codes held between samples
  always_comb
  begin
    raw_d       = raw_in.valid ? raw_in : raw_q;
    raw_d.valid = raw_in.valid;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      raw_q <= '0;
    end
    else
    begin
      raw_q <= raw_d;
    end
  end

  // Corrected pair, codes held until the next sample
  always_comb
  begin
    out_d       = out_q;
    out_d.valid = &sc_valid;
    if (&sc_valid)
    begin
      out_d.code_a = sc_code[0];
      out_d.code_b = sc_code[1];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_q <= '0;
    end
    else
    begin
      out_q <= out_d;
    end
  end

  assign raw_code[0] = raw_q.code_a;
  assign raw_code[1] = raw_q.code_b;

  // Per-channel scaling
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_chan
      agc_scale u_scale
      (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .in_valid  (raw_q.valid),
        .in_code   (raw_code[ch]),
        .gain      (gain_q[ch]),
        .out_valid (sc_valid[ch]),
        .out_code  (sc_code[ch])
      );
    end
  endgenerate

  // Serial shift, MSB first, one bit per clock, zero when done
  // A new sample cuts any frame still in progress
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      sh_d[i]   = sh_q[i];
      left_d[i] = left_q[i];
      if (left_q[i] != 4'h0)
      begin
        sh_d[i]   = {sh_q[i][12:0], 1'b0};
        left_d[i] = left_q[i] - 4'h1;
      end
      if (out_d.valid)
      begin
        sh_d[i]   = sc_code[i];
        left_d[i] = 4'(RESULT_W);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sh_q[0]   <= 14'h0000;
      sh_q[1]   <= 14'h0000;
      left_q[0] <= 4'h0;
      left_q[1] <= 4'h0;
    end
    else
    begin
      sh_q[0]   <= sh_d[0];
      sh_q[1]   <= sh_d[1];
      left_q[0] <= left_d[0];
      left_q[1] <= left_d[1];
    end
  end

  // Outputs, all from flip-flops
  assign hrdata                   = rdata_q;
  assign hreadyout                = ready_q;
  assign hresp                    = resp_q;
  assign corr_out                 = out_q;
  assign serial_result_out_first  = sh_q[0][13];
  assign serial_result_out_second = sh_q[1][13];

endmodule
